/* common/pic_pkg.sv */
// Purpose: Shared constants for the prioritised interrupt controller
// Assumes: 8-bit register port, 16 sources, four priority levels
// Notes:   Offsets are the register addresses on the register port
package pic_pkg;
    localparam int NUM_SRC = 16;
    localparam int IDX_W   = 4;
    localparam int LVL_W   = 2;
    localparam int VEC_W   = 16;
    localparam int SEL_W   = 3;

    // Register addresses
    localparam logic [7:0] OFF_EDGE_FLAG = 8'h88;
    localparam logic [7:0] OFF_ENABLE    = 8'hA8;
    localparam logic [7:0] OFF_PRIO_A    = 8'hB8;
    localparam logic [7:0] OFF_PRIO_B    = 8'hC0;
    localparam logic [7:0] OFF_PRIO_C    = 8'hC8;
    localparam logic [7:0] OFF_P1_EN     = 8'hD1;
    localparam logic [7:0] OFF_P1_FLAG   = 8'hD2;
    localparam logic [7:0] OFF_P2_EN     = 8'hD3;
    localparam logic [7:0] OFF_P2_FLAG   = 8'hD4;
    localparam logic [7:0] OFF_PRIO_D    = 8'hD8;

    // Enable register fields
    localparam int EN_GLOBAL   = 7;
    localparam int EN_CALENDAR = 6;
    localparam int EN_RSVD     = 5;
    localparam int EN_SERIAL1  = 4;
    localparam int EN_SPI      = 3;
    localparam int EN_LINE_B   = 2;
    localparam int EN_OVERTEMP = 1;
    localparam int EN_LINE_A   = 0;

    // Edge and flag register fields
    localparam int EF_OVERTEMP   = 5;
    localparam int EF_B_SEL_LO   = 3;
    localparam int EF_A_FLAG     = 2;
    localparam int EF_A_SEL_LO   = 0;

    // Fixed order numbers of sources whose enable lives here
    localparam int SRC_LV_OT    = 0;
    localparam int SRC_LINE_A   = 1;
    localparam int SRC_LINE_B   = 2;
    localparam int SRC_CALENDAR = 8;
    localparam int SRC_SERIAL1  = 13;
    localparam int SRC_SPI      = 14;

    // Edge select codes
    localparam logic [1:0] EDGE_RISE    = 2'h0;
    localparam logic [1:0] EDGE_FALL    = 2'h1;
    localparam int         EDGE_ANY_BIT = 1;

    // Line A source select: 0..3 are pins, this code is the comparator
    localparam logic [SEL_W-1:0] SEL_CMP = 3'h4;

    // Vectors and reset values
    localparam logic [VEC_W-1:0] VEC_RESET = 16'h0000;
    localparam logic [VEC_W-1:0] VEC_BASE  = 16'h0003;
    localparam logic [VEC_W-1:0] VEC_STEP  = 16'h0008;
    localparam logic [VEC_W-1:0] VEC_LAST  = 16'h007B;
    localparam logic [7:0]       RST_BYTE  = 8'h00;
endpackage : pic_pkg

/* src/pic_edge.sv */
// Purpose: Pin synchroniser and selectable edge detector
// Assumes: Pins are asynchronous to clock
// Notes:   A change counts once the second and third stages agree
`timescale 1ns/1ps
module pic_edge #(
    parameter int W = 1
) (
    input  wire logic                clock,
    input  wire logic                rst,
    input  wire logic [W-1:0]        raw,
    input  wire logic [1:0]          sel,
    output logic      [W-1:0]        hit
);
    import pic_pkg::*;

    logic [W-1:0] stage1;
    logic [W-1:0] stage2;
    logic [W-1:0] stage3;
    logic [W-1:0] level;
    logic         primed;
    logic [W-1:0] agree;
    logic [W-1:0] rise;
    logic [W-1:0] fall;

    ////////////////////////////////////////////////////////////////////
    // Three-stage synchroniser
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            stage1 <= '0;
            stage2 <= '0;
            stage3 <= '0;
        end else begin
            stage1 <= raw;
            stage2 <= stage1;
            stage3 <= stage2;
        end
    end

    // Filtered level; the first cycle after reset only loads it, so no false edge
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            level  <= '0;
            primed <= 1'b0;
        end else begin
            primed <= 1'b1;
            level  <= primed ? ((level & ~agree) | (stage3 & agree)) : stage3;
        end
    end

    // Qualifying edges, one cycle each
    always_comb begin
        agree = ~(stage2 ^ stage3);
        rise  = primed ? (agree & stage3 & ~level) : '0;
        fall  = primed ? (agree & ~stage3 & level) : '0;
        if (sel[EDGE_ANY_BIT]) begin
            hit = rise | fall;
        end else if (sel == EDGE_FALL) begin
            hit = fall;
        end else begin
            hit = rise;
        end
    end
endmodule : pic_edge

/* src/pic_top.sv */
// Purpose: Sixteen-source vectored interrupt controller with pin lines
// Assumes: CPU pulses irq_ack to take a request and irq_return at handler end
// Notes:   Request, level and vector are registered; one cycle of latency
//
// Strobed register access was chosen for this implementation.
`timescale 1ns/1ps
module pic_top (
    input  wire logic                         clock,
    input  wire logic                         rst,
    input  wire logic [7:0]                   reg_addr,
    input  wire logic [7:0]                   reg_wdata,
    input  wire logic                         reg_write,
    input  wire logic                         reg_read,
    output logic      [7:0]                   reg_rdata,
    input  wire logic [pic_pkg::NUM_SRC-1:0]  periph_req,
    input  wire logic                         lowvolt_req,
    input  wire logic                         overtemp_event,
    input  wire logic                         calendar_flag,
    input  wire logic                         serial_port1_flag,
    input  wire logic                         serial_periph_flag,
    input  wire logic [3:0]                   pin_line_a_pins,
    input  wire logic                         comparator_four_output,
    input  wire logic [pic_pkg::SEL_W-1:0]    pin_line_a_source_sel,
    input  wire logic [7:0]                   port1_pins,
    input  wire logic [7:0]                   port2_pins,
    output logic                              irq_req,
    output logic      [pic_pkg::LVL_W-1:0]    irq_level,
    output logic      [pic_pkg::VEC_W-1:0]    irq_vector,
    input  wire logic                         irq_ack,
    input  wire logic                         irq_return
);
    import pic_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // Helper functions

    // Winner: highest level, then smallest order number
    function automatic logic [IDX_W+LVL_W:0] pick(input logic [NUM_SRC-1:0] req,
                                                  input logic [2*NUM_SRC-1:0] prio);
        logic             found;
        logic [IDX_W-1:0] idx;
        logic [LVL_W-1:0] lvl;
        found = 1'b0;
        idx   = '0;
        lvl   = '0;
        for (int i = NUM_SRC - 1; i >= 0; i--) begin
            if (req[i] && (!found || prio[2*i +: LVL_W] >= lvl)) begin
                found = 1'b1;
                idx   = IDX_W'(i);
                lvl   = prio[2*i +: LVL_W];
            end
        end
        return {found, idx, lvl};
    endfunction : pick

    // Highest level in service
    function automatic logic [LVL_W:0] top_level(input logic [3:0] isr);
        logic [LVL_W:0] res;
        res = '0;
        for (int l = 0; l < 4; l++) begin
            if (isr[l]) begin
                res = {1'b1, LVL_W'(l)};
            end
        end
        return res;
    endfunction : top_level

    // Entry address for a fixed order number
    function automatic logic [VEC_W-1:0] vec_of(input logic [IDX_W-1:0] idx);
        return VEC_W'(VEC_BASE + VEC_W'(idx) * VEC_STEP);
    endfunction : vec_of

    ////////////////////////////////////////////////////////////////////
    // State

    logic [7:0]           en_reg;
    logic [2*NUM_SRC-1:0] prio_bits;
    logic                 overtemp_flag;
    logic                 pin_line_a_flag;
    logic [1:0]           pin_line_a_edge_sel;
    logic [1:0]           pin_line_b_edge_sel;
    logic [15:0]          pin_flags;
    logic [15:0]          pin_enables;
    logic [3:0]           in_service;
    logic [IDX_W-1:0]     irq_src;
    logic [NUM_SRC-1:0]   prev_req;

    logic                 global_irq_gate;
    logic                 pin_line_a_enable;
    logic                 pin_line_b_enable;
    logic                 line_a_raw;
    logic                 line_a_hit;
    logic [15:0]          line_b_hit;
    logic                 wr_edge;
    logic                 wr_en;
    logic                 wr_p1_en;
    logic                 wr_p1_flag;
    logic                 wr_p2_en;
    logic                 wr_p2_flag;
    logic [3:0]           wr_prio;
    logic [7:0]           next_rdata;
    logic [NUM_SRC-1:0]   live_req;
    logic [NUM_SRC-1:0]   gated_req;
    logic [IDX_W+LVL_W:0] win;
    logic [LVL_W:0]       cur;
    logic                 take_ok;
    logic [3:0]           next_in_service;
    logic [15:0]          pin_clear;
    logic                 rank_fault;

    assign global_irq_gate   = en_reg[EN_GLOBAL];
    assign pin_line_a_enable = en_reg[EN_LINE_A];
    assign pin_line_b_enable = en_reg[EN_LINE_B];

    ////////////////////////////////////////////////////////////////////
    // Pin lines

    // Line A trigger source selection
    always_comb begin
        if (pin_line_a_source_sel == SEL_CMP) begin
            line_a_raw = comparator_four_output;
        end else if (pin_line_a_source_sel < SEL_CMP) begin
            line_a_raw = pin_line_a_pins[pin_line_a_source_sel[1:0]];
        end else begin
            line_a_raw = 1'b0;
        end
    end

    // Synchronised edge detection on both lines
    pic_edge #(.W(1)) u_edge_a (
        .clock (clock),
        .rst   (rst),
        .raw   (line_a_raw),
        .sel   (pin_line_a_edge_sel),
        .hit   (line_a_hit)
    );

    pic_edge #(.W(16)) u_edge_b (
        .clock (clock),
        .rst   (rst),
        .raw   ({port2_pins, port1_pins}),
        .sel   (pin_line_b_edge_sel),
        .hit   (line_b_hit)
    );

    ////////////////////////////////////////////////////////////////////
    // Register port decode and read data

    always_comb begin
        wr_edge    = 1'b0;
        wr_en      = 1'b0;
        wr_p1_en   = 1'b0;
        wr_p1_flag = 1'b0;
        wr_p2_en   = 1'b0;
        wr_p2_flag = 1'b0;
        wr_prio    = '0;
        next_rdata = RST_BYTE;
        if (reg_addr == OFF_EDGE_FLAG) begin
            wr_edge    = reg_write;
            next_rdata = {2'h0, overtemp_flag, pin_line_b_edge_sel,
                          pin_line_a_flag, pin_line_a_edge_sel};
        end else if (reg_addr == OFF_ENABLE) begin
            wr_en      = reg_write;
            next_rdata = en_reg;
        end else if (reg_addr == OFF_PRIO_A) begin
            wr_prio[0] = reg_write;
            next_rdata = prio_bits[7:0];
        end else if (reg_addr == OFF_PRIO_B) begin
            wr_prio[1] = reg_write;
            next_rdata = prio_bits[15:8];
        end else if (reg_addr == OFF_PRIO_C) begin
            wr_prio[2] = reg_write;
            next_rdata = prio_bits[23:16];
        end else if (reg_addr == OFF_PRIO_D) begin
            wr_prio[3] = reg_write;
            next_rdata = prio_bits[31:24];
        end else if (reg_addr == OFF_P1_EN) begin
            wr_p1_en   = reg_write;
            next_rdata = pin_enables[7:0];
        end else if (reg_addr == OFF_P1_FLAG) begin
            wr_p1_flag = reg_write;
            next_rdata = pin_flags[7:0];
        end else if (reg_addr == OFF_P2_EN) begin
            wr_p2_en   = reg_write;
            next_rdata = pin_enables[15:8];
        end else if (reg_addr == OFF_P2_FLAG) begin
            wr_p2_flag = reg_write;
            next_rdata = pin_flags[15:8];
        end
    end

    // Read data stands in the cycle after the read strobe only
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            reg_rdata <= RST_BYTE;
        end else begin
            reg_rdata <= reg_read ? next_rdata : RST_BYTE;
        end
    end

    // Enable register; reserved bit kept at zero
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            en_reg <= RST_BYTE;
        end else if (wr_en) begin
            en_reg           <= reg_wdata;
            en_reg[EN_RSVD]  <= 1'b0;
        end
    end

    // Priority fields, two bits per source in order number sequence
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            prio_bits <= '0;
        end else begin
            for (int g = 0; g < 4; g++) begin
                if (wr_prio[g]) begin
                    prio_bits[8*g +: 8] <= reg_wdata;
                end
            end
        end
    end

    // Edge selects
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            pin_line_a_edge_sel <= EDGE_RISE;
            pin_line_b_edge_sel <= EDGE_RISE;
        end else if (wr_edge) begin
            pin_line_a_edge_sel <= reg_wdata[EF_A_SEL_LO +: 2];
            pin_line_b_edge_sel <= reg_wdata[EF_B_SEL_LO +: 2];
        end
    end

    // Hardware-set flags: set wins over a clearing write of 0
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            overtemp_flag   <= 1'b0;
            pin_line_a_flag <= 1'b0;
        end else begin
            overtemp_flag   <= overtemp_event |
                (overtemp_flag & ~(wr_edge & ~reg_wdata[EF_OVERTEMP]));
            pin_line_a_flag <= line_a_hit |
                (pin_line_a_flag & ~(wr_edge & ~reg_wdata[EF_A_FLAG]));
        end
    end

    // Per-pin flags of line B, cleared by writing 0
    assign pin_clear = {wr_p2_flag ? ~reg_wdata : RST_BYTE,
                        wr_p1_flag ? ~reg_wdata : RST_BYTE};

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            pin_flags <= '0;
        end else begin
            pin_flags <= (pin_flags & ~pin_clear) | line_b_hit;
        end
    end

    // Per-pin enables of line B
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            pin_enables <= '0;
        end else begin
            if (wr_p1_en) begin
                pin_enables[7:0] <= reg_wdata;
            end
            if (wr_p2_en) begin
                pin_enables[15:8] <= reg_wdata;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Source requests and arbitration

    // Flags stay pending; only the request is gated by the enables
    always_comb begin
        live_req = periph_req;
        live_req[SRC_LV_OT]    = lowvolt_req |
                                 (en_reg[EN_OVERTEMP] & overtemp_flag);
        live_req[SRC_LINE_A]   = pin_line_a_enable & pin_line_a_flag;
        live_req[SRC_LINE_B]   = pin_line_b_enable & |(pin_flags & pin_enables);
        live_req[SRC_CALENDAR] = periph_req[SRC_CALENDAR] |
                                 (en_reg[EN_CALENDAR] & calendar_flag);
        live_req[SRC_SERIAL1]  = periph_req[SRC_SERIAL1] |
                                 (en_reg[EN_SERIAL1] & serial_port1_flag);
        live_req[SRC_SPI]      = periph_req[SRC_SPI] |
                                 (en_reg[EN_SPI] & serial_periph_flag);
        gated_req = global_irq_gate ? live_req : '0;
    end

    assign win     = pick(gated_req, prio_bits);
    assign cur     = top_level(in_service);
    // Only a strictly higher level may interrupt the running handler
    assign take_ok = win[IDX_W+LVL_W] &&
                     (!cur[LVL_W] || win[LVL_W-1:0] > cur[LVL_W-1:0]);

    // Registered request, level and vector; request dropped in the cycle after the ack cycle
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            irq_req    <= 1'b0;
            irq_level  <= '0;
            irq_src    <= '0;
            irq_vector <= VEC_RESET;
        end else begin
            irq_req    <= take_ok && !irq_ack;
            irq_level  <= win[LVL_W-1:0];
            irq_src    <= win[IDX_W+LVL_W-1:LVL_W];
            irq_vector <= take_ok ? vec_of(win[IDX_W+LVL_W-1:LVL_W]) : VEC_RESET;
        end
    end

    // In-service levels: return pops the highest, ack pushes the new one
    always_comb begin
        next_in_service = in_service;
        if (irq_return && cur[LVL_W]) begin
            next_in_service[cur[LVL_W-1:0]] = 1'b0;
        end
        if (irq_ack && irq_req) begin
            next_in_service[irq_level] = 1'b1;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            in_service <= '0;
            prev_req   <= '0;
        end else begin
            in_service <= next_in_service;
            prev_req   <= gated_req;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Checks

    gate_off_blocks_a: assert property (
        @(posedge clock) disable iff (rst)
        !global_irq_gate |=> !irq_req)
        else $error("request raised with the global gate off");

    vector_shape_a: assert property (
        @(posedge clock) disable iff (rst)
        irq_req |-> (irq_vector[2:0] == VEC_BASE[2:0]) && (irq_vector <= VEC_LAST))
        else $error("request vector off the entry grid");

    equal_level_hold_a: assert property (
        @(posedge clock) disable iff (rst)
        irq_req && cur[LVL_W] |-> irq_level > cur[LVL_W-1:0])
        else $error("request does not outrank handler in service");

    // Arbitration check: every request passed over must rank below the winner
    always_comb begin
        rank_fault = 1'b0;
        for (int j = 0; j < NUM_SRC; j++) begin
            if (prev_req[j] && (prio_bits[2*j +: LVL_W] > irq_level ||
                (prio_bits[2*j +: LVL_W] == irq_level && IDX_W'(j) < irq_src))) begin
                rank_fault = 1'b1;
            end
        end
    end

    tie_break_order_a: assert property (
        @(posedge clock) disable iff (rst)
        irq_req |-> !rank_fault)
        else $error("winner does not outrank every other request");

    overtemp_set_wins_a: assert property (
        @(posedge clock) disable iff (rst)
        overtemp_event |=> overtemp_flag)
        else $error("overtemp event lost");

    line_a_flag_hold_a: assert property (
        @(posedge clock) disable iff (rst)
        pin_line_a_flag && !wr_edge |=> pin_line_a_flag)
        else $error("line A flag dropped without a write");

    pending_taken_a: assert property (
        @(posedge clock) disable iff (rst)
        (gated_req != '0) && !cur[LVL_W] && !irq_ack |=> irq_req)
        else $error("pending enabled request not presented");

    ack_pushes_level_a: assert property (
        @(posedge clock) disable iff (rst)
        irq_ack && irq_req && !irq_return |=> cur[LVL_W] && cur[LVL_W-1:0] == $past(irq_level))
        else $error("taken request not marked in service");

    reserved_bit_zero_a: assert property (
        @(posedge clock) disable iff (rst)
        reg_read && reg_addr == OFF_ENABLE |=> !reg_rdata[EN_RSVD])
        else $error("reserved enable bit reads as one");
endmodule : pic_top

/* sim/pic_cpu_model.sv */
// Purpose: CPU side model that takes vectored requests
// Assumes: A request stands until it is acknowledged
// Notes:   ack_wait sets how slowly a request is taken
`timescale 1ns/1ps
module pic_cpu_model (
    input  wire logic        clock,
    input  wire logic        rst,
    input  wire logic        irq_req,
    input  wire logic [15:0] irq_vector,
    input  wire logic        take,
    input  wire logic [3:0]  ack_wait,
    input  wire logic        finish,
    output logic             irq_ack,
    output logic             irq_return,
    output logic      [15:0] taken_vector,
    output logic      [7:0]  taken_count
);
    logic [3:0] wait_cnt;
    ////////////////////////////////////////////////////////////////////////////
    // One-cycle ack after the wait, one-cycle return when asked
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            irq_ack      <= 1'h0;
            irq_return   <= 1'h0;
            wait_cnt     <= 4'h0;
            taken_vector <= 16'h0000;
            taken_count  <= 8'h00;
        end else begin
            irq_ack    <= irq_req && take && !irq_ack && wait_cnt >= ack_wait;
            irq_return <= finish && !irq_return;
            wait_cnt   <= (irq_req && !irq_ack) ? wait_cnt + 4'h1 : 4'h0;
            if (irq_ack && irq_req) begin
                taken_vector <= irq_vector;
                taken_count  <= taken_count + 8'h01;
            end
        end
    end
endmodule : pic_cpu_model

/* sim/pic_top_bench.sv */
// Purpose: Self-checking bench for the interrupt controller
// Assumes: CPU side is played by pic_cpu_model
// Notes:   Inputs change by non-blocking assignment at rising edges
`timescale 1ns/1ps
module pic_top_bench;
    import pic_pkg::*;
    logic        clock = 1'h0, rst = 1'h1, reg_write = 1'h0, reg_read = 1'h0;
    logic        ot = 1'h0, cmp = 1'h0, take = 1'h0, fin = 1'h0, req, ack, ret, cal = 1'h0;
    logic [3:0]  wt = 4'h0, apins = 4'h0;
    logic [2:0]  asel = 3'h1;
    logic [7:0]  addr = 8'h00, wdata = 8'h00, rdata, tcnt;
    logic [15:0] preq = 16'h0000, bpins = 16'h0000, vec, tvec;
    logic [1:0]  lvl;
    int          errors = 0, samples_checked = 0;
    logic [7:0]  regs [11] = '{OFF_EDGE_FLAG, OFF_ENABLE, OFF_PRIO_A, OFF_PRIO_B, OFF_PRIO_C,
        OFF_P1_EN, OFF_P1_FLAG, OFF_P2_EN, OFF_P2_FLAG, OFF_PRIO_D, 8'h90};
    always #12.5 clock = ~clock;
    pic_top dut (.clock(clock), .rst(rst), .reg_addr(addr), .reg_wdata(wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(rdata), .periph_req(preq),
        .lowvolt_req(1'h0), .overtemp_event(ot), .calendar_flag(cal),
        .serial_port1_flag(1'h0), .serial_periph_flag(1'h0), .pin_line_a_pins(apins),
        .comparator_four_output(cmp), .pin_line_a_source_sel(asel),
        .port1_pins(bpins[7:0]), .port2_pins(bpins[15:8]), .irq_req(req),
        .irq_level(lvl), .irq_vector(vec), .irq_ack(ack), .irq_return(ret));
    pic_cpu_model cpu (.clock(clock), .rst(rst), .irq_req(req), .irq_vector(vec),
        .take(take), .ack_wait(wt), .finish(fin), .irq_ack(ack), .irq_return(ret),
        .taken_vector(tvec), .taken_count(tcnt));
    ////////////////////////////////////////////////////////////////////////////
    // Shared compare, bus and CPU tasks
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        addr <= a;
        wdata <= d;
        reg_write <= 1'h1;
        @(posedge clock) reg_write <= 1'h0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clock);
        addr <= a;
        reg_read <= 1'h1;
        @(posedge clock) reg_read <= 1'h0;
        #1 chk({8'h00, rdata}, {8'h00, exp});
    endtask : rd
    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : cyc
    task automatic serve(input logic [15:0] v, input logic [1:0] l);
        int i;
        logic [7:0] c0;
        i = 0;
        c0 = tcnt;
        do begin cyc(1); i++; end while (req !== 1'h1 && i < 40);
        if (req !== 1'h1) begin errors++; results(); end
        chk(vec, v);
        chk({14'h0000, lvl}, {14'h0000, l});
        @(posedge clock) take <= 1'h1;
        do begin cyc(1); i++; end while (tcnt === c0 && i < 80);
        if (tcnt === c0) begin errors++; results(); end
        @(posedge clock) take <= 1'h0;
        chk(tvec, v);
    endtask : serve
    task automatic done;
        @(posedge clock) fin <= 1'h1;
        @(posedge clock) fin <= 1'h0;
    endtask : done
    task automatic results;
        $display("comparisons %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : results
    ////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        repeat (20) @(posedge clock);
        rst <= 1'h0;
        foreach (regs[i]) rd(regs[i], 8'h00);
        chk(vec, VEC_RESET);
        wr(OFF_ENABLE, 8'hFF);
        rd(OFF_ENABLE, 8'hDF);
        wr(OFF_PRIO_B, 8'hA5);
        rd(OFF_PRIO_B, 8'hA5);
        wr(OFF_PRIO_B, 8'h00);
        wr(OFF_ENABLE, 8'h02);
        @(posedge clock) ot <= 1'h1;
        @(posedge clock) ot <= 1'h0;
        wr(OFF_EDGE_FLAG, 8'h20);
        rd(OFF_EDGE_FLAG, 8'h20);
        cyc(4);
        chk({15'h0000, req}, 16'h0000);
        wr(OFF_ENABLE, 8'h82);
        serve(VEC_BASE, 2'h0);
        wr(OFF_EDGE_FLAG, 8'h00);
        rd(OFF_EDGE_FLAG, 8'h00);
        done;
        for (int n = 3; n < 16; n++) begin
            @(posedge clock) preq <= 16'h0001 << n;
            serve(16'(VEC_BASE + VEC_STEP * n), 2'h0);
            @(posedge clock) preq <= 16'h0000;
            done;
        end
        // Tie, equal level hold-off and preemption
        @(posedge clock) preq <= 16'h0220;
        serve(16'h002B, 2'h0);
        cyc(8);
        chk({15'h0000, req}, 16'h0000);
        wr(OFF_PRIO_C, 8'h0C);
        serve(16'h004B, 2'h3);
        @(posedge clock) preq <= 16'h0030;
        done;
        cyc(8);
        chk({15'h0000, req}, 16'h0000);
        done;
        serve(16'h0023, 2'h0);
        @(posedge clock) preq <= 16'h0000;
        done;
        wr(OFF_PRIO_C, 8'h00);
        // Edge codes 0 to 2 on line A, rise then fall
        for (int e = 0; e < 3; e++) begin
            wr(OFF_EDGE_FLAG, 8'(e));
            @(posedge clock) apins <= 4'h2;
            cyc(8);
            rd(OFF_EDGE_FLAG, 8'(e) | ((e != 1) ? 8'h04 : 8'h00));
            wr(OFF_EDGE_FLAG, 8'(e));
            @(posedge clock) apins <= 4'h0;
            cyc(8);
            rd(OFF_EDGE_FLAG, 8'(e) | ((e != 0) ? 8'h04 : 8'h00));
        end
        wr(OFF_EDGE_FLAG, 8'h06);
        rd(OFF_EDGE_FLAG, 8'h06);
        @(posedge clock) asel <= SEL_CMP;
        wr(OFF_EDGE_FLAG, 8'h00);
        @(posedge clock) cmp <= 1'h1;
        cyc(8);
        rd(OFF_EDGE_FLAG, 8'h04);
        @(posedge clock) wt <= 4'h5;
        wr(OFF_ENABLE, 8'h81);
        serve(16'h000B, 2'h0);
        wr(OFF_EDGE_FLAG, 8'h00);
        done;
        // Multi-pin line: line enable first, then the pin enable
        wr(OFF_ENABLE, 8'h84);
        wr(OFF_P2_EN, 8'h08);
        @(posedge clock) bpins <= 16'h0800;
        serve(16'h0013, 2'h0);
        wr(OFF_P2_FLAG, 8'h08);
        rd(OFF_P2_FLAG, 8'h08);
        wr(OFF_P2_FLAG, 8'h00);
        rd(OFF_P2_FLAG, 8'h00);
        done;
        // Calendar flag waits for its own enable
        @(posedge clock) cal <= 1'h1;
        cyc(4);
        chk({15'h0000, req}, 16'h0000);
        wr(OFF_ENABLE, 8'hC0);
        serve(16'h0043, 2'h0);
        @(posedge clock) cal <= 1'h0;
        done;
        results();
    end
endmodule : pic_top_bench
